// ==== design/ccl_cfg.svh ====
// Constants for the cursor, start address and light pen block.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH

// Register indices; the byte address is four times the index.
`define CCL_IDX_MAX_SCAN     6'd9
`define CCL_IDX_CUR_START    6'd10
`define CCL_IDX_CUR_END      6'd11
`define CCL_IDX_START_HIGH   6'd12
`define CCL_IDX_START_LOW    6'd13
`define CCL_IDX_CUR_HIGH     6'd14
`define CCL_IDX_CUR_LOW      6'd15
`define CCL_IDX_PEN_HIGH     6'd16
`define CCL_IDX_PEN_LOW      6'd17
`define CCL_IDX_STATUS       6'd18

// Field positions inside the cursor start setting.
`define CCL_CS_LINE_MSB      4
`define CCL_CS_RATE_BIT      5
`define CCL_CS_BLINK_BIT     6

// Field positions inside the status register.
`define CCL_ST_PEN_BIT       0

// Blink period bits of the field counter: 16 and 32 fields.
`define CCL_BLINK_FAST_BIT   3
`define CCL_BLINK_SLOW_BIT   4

// Reset values.
`define CCL_RST_SCAN         5'h00
`define CCL_RST_ADDR         14'h0000
`define CCL_RST_CURSOR_START 5'h00
`define CCL_RST_CURSOR_END   5'h00

`endif

// ==== design/ccl_pkg.sv ====
// Types shared by the cursor, start address and light pen block.
// Assumes ccl_cfg.svh supplies the numeric constants.
package ccl_pkg;

    typedef logic [13:0] ccl_addr_t;
    typedef logic [4:0]  ccl_line_t;

    typedef struct packed {
        ccl_line_t max_scan;
        ccl_line_t cur_start;
        logic      blink_en;
        logic      blink_slow;
        ccl_line_t cur_end;
        ccl_addr_t start_addr;
        ccl_addr_t cur_addr;
    } ccl_set_s;

    typedef struct packed {
        ccl_addr_t addr;
        ccl_addr_t row_start;
        ccl_line_t line;
        logic [4:0] fields;
    } ccl_scan_s;

endpackage

// ==== design/ccl_top.sv ====
// Cursor overlay, display start address and light pen capture logic.
// Assumes raster timing comes from logic on clk_i: one pulse per scan
// line end, one per vertical retrace, and a display enable level.
//
// Operation
// R1: Count scan lines per row up to the maximum scan line setting.
// R2: Cursor starts on the scan line given by cursor start setting.
// R3: One cursor start bit selects blinking or steady cursor.
// R4: Another bit picks blink at 1/16 or 1/32 field rate.
// R5: Cursor stops after the scan line given by cursor end setting.
// R6: Equal start and end settings give a one-line cursor.
// R7: Each vertical retrace reloads refresh address from display start.
// R8: Cursor appears where refresh address equals cursor address setting.
// R9: Light pen strobe rise captures refresh address at next edge; here it captures on the fourth clock edge, after three sync stages.
// R10: Refresh addresses run linearly across row boundaries.
// R11: Host loads all settings at start, blanking memory first.
// R12: Host scrolls by adding or subtracting characters per row.
// R13: Only cursor address is read/write; start address is write-only. Here max scan, cursor start and cursor end also read back.
// R14: Cursor only during display enable, hidden in blink off half.
`timescale 1ns/1ns
`include "ccl_cfg.svh"

module ccl_top
    import ccl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        disp_en_i,
    input  wire logic        line_end_i,
    input  wire logic        field_start_i,
    input  wire logic        light_pen_strobe_i,
    output logic      [13:0] refresh_addr_o,
    output logic      [4:0]  row_addr_o,
    output logic             cursor_o
);

    ccl_set_s   set_q, set_d;
    ccl_scan_s  scan_q, scan_d;
    logic       ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    ccl_addr_t  pen_q, pen_d;
    logic       pen_flag_q, pen_flag_d;
    logic       cursor_q, cursor_d;
    logic       pen_s1_q, pen_s2_q, pen_s3_q, pen_stab_q;
    logic       pen_rise;
    logic [5:0] idx;
    logic       wr_take;
    logic       blink_off;

    assign idx     = adr_i[7:2];
    // The write lands on the edge at which the master samples ack.
    assign wr_take = cyc_i & stb_i & we_i & ack_q & sel_i[0];

    // Pen strobe is a pin: three stages, a change counts once stages two
    // and three agree, so a single-cycle glitch never captures.
    assign pen_rise = pen_s2_q & pen_s3_q & ~pen_stab_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pen_s1_q   <= 1'b0;
            pen_s2_q   <= 1'b0;
            pen_s3_q   <= 1'b0;
            pen_stab_q <= 1'b0;
        end else begin
            pen_s1_q <= light_pen_strobe_i;
            pen_s2_q <= pen_s1_q;
            pen_s3_q <= pen_s2_q;
            if (pen_s2_q == pen_s3_q) begin
                pen_stab_q <= pen_s3_q;
            end
        end
    end

    // Settings written by software.
    always_comb begin
        set_d = set_q;
        if (wr_take) begin
            unique case (idx)
                `CCL_IDX_MAX_SCAN:   set_d.max_scan   = dat_i[4:0];
                `CCL_IDX_CUR_START: begin
                    set_d.cur_start  = dat_i[`CCL_CS_LINE_MSB:0];
                    set_d.blink_en   = dat_i[`CCL_CS_BLINK_BIT];
                    set_d.blink_slow = dat_i[`CCL_CS_RATE_BIT];
                end
                `CCL_IDX_CUR_END:    set_d.cur_end    = dat_i[4:0];
                `CCL_IDX_START_HIGH: set_d.start_addr[13:8] = dat_i[5:0];
                `CCL_IDX_START_LOW:  set_d.start_addr[7:0]  = dat_i[7:0];
                `CCL_IDX_CUR_HIGH:   set_d.cur_addr[13:8]   = dat_i[5:0];
                `CCL_IDX_CUR_LOW:    set_d.cur_addr[7:0]    = dat_i[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            set_q.max_scan   <= `CCL_RST_SCAN;
            set_q.cur_start  <= `CCL_RST_CURSOR_START;
            set_q.blink_en   <= 1'b0;
            set_q.blink_slow <= 1'b0;
            set_q.cur_end    <= `CCL_RST_CURSOR_END;
            set_q.start_addr <= `CCL_RST_ADDR;
            set_q.cur_addr   <= `CCL_RST_ADDR;
        end else begin
            set_q <= set_d;
        end
    end

    // Bus answer: ack one cycle after the request, dropped the next.
    always_comb begin
        ack_d  = cyc_i & stb_i & ~ack_q;
        rdat_d = 32'h0000_0000;
        if (cyc_i & stb_i & ~we_i & ~ack_q) begin
            unique case (idx)
                `CCL_IDX_MAX_SCAN:  rdat_d[4:0] = set_q.max_scan;
                `CCL_IDX_CUR_START: begin
                    rdat_d[`CCL_CS_LINE_MSB:0] = set_q.cur_start;
                    rdat_d[`CCL_CS_BLINK_BIT]  = set_q.blink_en;
                    rdat_d[`CCL_CS_RATE_BIT]   = set_q.blink_slow;
                end
                `CCL_IDX_CUR_END:   rdat_d[4:0] = set_q.cur_end;
                // Start address reads zero; software keeps its own copy.
                `CCL_IDX_CUR_HIGH:  rdat_d[5:0] = set_q.cur_addr[13:8]; // see R13
                `CCL_IDX_CUR_LOW:   rdat_d[7:0] = set_q.cur_addr[7:0];  // see R13
                `CCL_IDX_PEN_HIGH:  rdat_d[5:0] = pen_q[13:8];
                `CCL_IDX_PEN_LOW:   rdat_d[7:0] = pen_q[7:0];
                `CCL_IDX_STATUS:    rdat_d[`CCL_ST_PEN_BIT] = pen_flag_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Refresh scan: address, row start, scan line and field count.
    always_comb begin
        scan_d = scan_q;
        if (field_start_i) begin
            scan_d.addr      = set_q.start_addr; // see R7
            scan_d.row_start = set_q.start_addr;
            scan_d.line      = 5'h00;
            scan_d.fields    = 5'(scan_q.fields + 5'h01); // see R4
        end else if (line_end_i) begin
            if (scan_q.line == set_q.max_scan) begin // see R1
                // Next row begins right after the last character drawn.
                scan_d.line      = 5'h00;
                scan_d.row_start = scan_q.addr; // see R10
            end else begin
                scan_d.line = 5'(scan_q.line + 5'h01);
                scan_d.addr = scan_q.row_start;
            end
        end else if (disp_en_i) begin
            scan_d.addr = 14'(scan_q.addr + 14'h0001); // see R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_q.addr      <= `CCL_RST_ADDR;
            scan_q.row_start <= `CCL_RST_ADDR;
            scan_q.line      <= `CCL_RST_SCAN;
            scan_q.fields    <= 5'h00;
        end else begin
            scan_q <= scan_d;
        end
    end

    // Blink: hidden while the chosen field counter bit is high.
    assign blink_off = set_q.blink_en &                              // see R3
        (set_q.blink_slow ? scan_q.fields[`CCL_BLINK_SLOW_BIT]
                          : scan_q.fields[`CCL_BLINK_FAST_BIT]);    // see R4

    // Cursor overlay; equal start and end give a single line.
    always_comb begin
        cursor_d = disp_en_i                                 // see R14
                 & ~blink_off                                // see R14
                 & (scan_q.addr == set_q.cur_addr)           // see R8
                 & (scan_q.line >= set_q.cur_start)          // see R2
                 & (scan_q.line <= set_q.cur_end);           // see R5 R6
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cursor_q <= 1'b0;
        end else begin
            cursor_q <= cursor_d;
        end
    end

    // Light pen capture and its sticky flag; a new capture beats a clear.
    always_comb begin
        pen_d      = pen_q;
        pen_flag_d = pen_flag_q;
        if (wr_take && idx == `CCL_IDX_STATUS && dat_i[`CCL_ST_PEN_BIT]) begin
            pen_flag_d = 1'b0;
        end
        if (pen_rise) begin
            pen_d      = scan_q.addr; // see R9
            pen_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pen_q      <= `CCL_RST_ADDR;
            pen_flag_q <= 1'b0;
        end else begin
            pen_q      <= pen_d;
            pen_flag_q <= pen_flag_d;
        end
    end

    assign dat_o          = rdat_q;
    assign ack_o          = ack_q;
    assign refresh_addr_o = scan_q.addr;
    assign row_addr_o     = scan_q.line;
    assign cursor_o       = cursor_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_scan_wrap: assert property ( // see R1
        line_end_i && !field_start_i && scan_q.line == set_q.max_scan
        |=> scan_q.line == 5'h00)
        else $error("scan line did not wrap at maximum");

    a_cursor_top: assert property ( // see R2
        cursor_o |-> $past(scan_q.line) >= $past(set_q.cur_start))
        else $error("cursor drawn above start line");

    a_blink_hide: assert property ( // see R3
        set_q.blink_en && !set_q.blink_slow
        && scan_q.fields[`CCL_BLINK_FAST_BIT] ##1 $stable(set_q)
        |-> !cursor_o)
        else $error("cursor shown in fast blink off half");

    a_slow_hide: assert property ( // see R4
        set_q.blink_en && set_q.blink_slow
        && scan_q.fields[`CCL_BLINK_SLOW_BIT] ##1 $stable(set_q)
        |-> !cursor_o)
        else $error("cursor shown in slow blink off half");

    a_cursor_bottom: assert property ( // see R5
        cursor_o |-> $past(scan_q.line) <= $past(set_q.cur_end))
        else $error("cursor drawn below end line");

    a_one_line: assert property ( // see R6
        cursor_o && $past(set_q.cur_start) == $past(set_q.cur_end)
        |-> $past(scan_q.line) == $past(set_q.cur_start))
        else $error("single line cursor drawn on wrong line");

    a_start_reload: assert property ( // see R7
        field_start_i |=> scan_q.addr == $past(set_q.start_addr)
                          && scan_q.line == 5'h00)
        else $error("refresh address not reloaded at retrace");

    a_cursor_match: assert property ( // see R8
        cursor_o |-> $past(scan_q.addr) == $past(set_q.cur_addr))
        else $error("cursor away from cursor address");

    a_pen_capture: assert property ( // see R9
        pen_rise |=> pen_q == $past(scan_q.addr) && pen_flag_q)
        else $error("light pen address not captured");

    a_linear_step: assert property ( // see R10
        disp_en_i && !line_end_i && !field_start_i
        |=> scan_q.addr == 14'($past(scan_q.addr) + 14'h0001))
        else $error("refresh address did not step by one");

    a_start_noread: assert property ( // see R13
        cyc_i && stb_i && !we_i && !ack_q
        && (idx == `CCL_IDX_START_HIGH || idx == `CCL_IDX_START_LOW)
        |=> ack_q && dat_o == 32'h0000_0000)
        else $error("start address readable");

    a_de_gate: assert property ( // see R14
        !disp_en_i |=> !cursor_o)
        else $error("cursor outside display enable");

    a_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_line_step: assert property ( // see R1
        line_end_i && !field_start_i && scan_q.line != set_q.max_scan
        |=> scan_q.line == 5'($past(scan_q.line) + 5'h01)
            && scan_q.addr == $past(scan_q.row_start))
        else $error("scan line did not advance within row");

    a_field_count: assert property ( // see R4
        field_start_i |=> scan_q.fields == 5'($past(scan_q.fields) + 5'h01))
        else $error("field counter did not advance at retrace");

    a_steady_show: assert property ( // see R3
        disp_en_i && !set_q.blink_en && scan_q.addr == set_q.cur_addr
        && scan_q.line >= set_q.cur_start && scan_q.line <= set_q.cur_end
        |=> cursor_o)
        else $error("steady cursor not drawn");

    a_row_carry: assert property ( // see R10
        line_end_i && !field_start_i && scan_q.line == set_q.max_scan
        |=> scan_q.row_start == $past(scan_q.addr)
            && scan_q.addr == $past(scan_q.addr))
        else $error("next row does not follow the last character");

    // A capture only moves on a recognised rise; the flag stays until
    // software clears it.
    a_pen_hold: assert property ( // see R9
        !pen_rise |=> pen_q == $past(pen_q))
        else $error("light pen address changed without a strobe");

    a_pen_sticky: assert property ( // see R9
        pen_flag_q && !(wr_take && idx == `CCL_IDX_STATUS
                        && dat_i[`CCL_ST_PEN_BIT])
        |=> pen_flag_q)
        else $error("light pen flag lost without a clear");

    a_pen_settle: assert property ( // see R9
        pen_s2_q == pen_s3_q |=> pen_stab_q == $past(pen_s3_q))
        else $error("pen strobe level not taken once settled");

    a_bus_answer: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");

    a_read_idle: assert property (
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data shown without ack");

    c_cursor_seen: cover property (cursor_o);
    c_pen_hit: cover property (pen_rise ##1 pen_flag_q);
    c_row_wrap: cover property (
        line_end_i && scan_q.line == set_q.max_scan ##1 disp_en_i);
    c_blink_toggle: cover property (
        set_q.blink_en ##1 $changed(blink_off));
    c_one_line: cover property (cursor_o && set_q.cur_start == set_q.cur_end);

endmodule

// ==== sim/ccl_host.sv ====
// Host model: a classic Wishbone master that programs the block.
// Assumes a slave that answers every request with one ack pulse.
`timescale 1ns/1ns
`include "ccl_cfg.svh"

module ccl_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [31:0] dat_o
);
    logic [13:0] start_q;

    initial begin
        cyc_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0;
        start_q = 14'h0000;
    end

    task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
              output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= {idx, 2'b00};
        dat_o <= {24'h0, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        we_o <= 1'b0;
        // Released lines carry junk so a stale value is never trusted.
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask

    task init;
        logic [31:0] q;
        for (int i = 9; i < 16; i++) begin
            xfer(1'b1, 6'(i), 8'h00, q);
        end
    endtask

    // Start address reads back as zero, so the host keeps a copy.
    task set_start(input logic [13:0] a);
        logic [31:0] q;
        start_q = a;
        xfer(1'b1, `CCL_IDX_START_HIGH, {2'b00, a[13:8]}, q);
        xfer(1'b1, `CCL_IDX_START_LOW, a[7:0], q);
    endtask

    task scroll(input logic [13:0] cpr);
        set_start(start_q + cpr);
    endtask
endmodule

// ==== sim/ccl_top_bench.sv ====
// Bench for the cursor, start address and light pen block.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ns

module ccl_top_bench;
    import ccl_pkg::*;
    logic        clk_i, rst_i, cyc, we, de, le, fs, lp, ack, cur;
    logic        m_cur, bl, sl;
    logic [7:0]  adr, v;
    logic [31:0] wd, rdat, q;
    logic [4:0]  m_f;
    ccl_addr_t   ra, m_addr, m_rs, sa, ca;
    ccl_line_t   rw, m_line, ms, cs, ce;
    int          err_count, samples_checked, seed;
    logic [5:0]  ix[5] = '{6'h09, 6'h0a, 6'h0b, 6'h0e, 6'h0f};
    logic [7:0]  mk[5] = '{8'h1f, 8'h7f, 8'h1f, 8'h3f, 8'hff};

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    ccl_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
        .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wd), .dat_o(rdat),
        .ack_o(ack), .disp_en_i(de), .line_end_i(le), .field_start_i(fs),
        .light_pen_strobe_i(lp), .refresh_addr_o(ra), .row_addr_o(rw),
        .cursor_o(cur));
    ccl_host host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .we_o(we), .adr_o(adr), .dat_o(wd));

    task finish_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: read %h want %h", $time, got, exp);
        end
    endtask

    task chk_out(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: raster %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [5:0] i, input logic [7:0] d);
        host_u.xfer(1'b1, i, d, q);
    endtask

    task rdc(input logic [5:0] i, input logic [31:0] e);
        host_u.xfer(1'b0, i, 8'h00, q);
        chk_reg(q, e);
    endtask

    function automatic logic cur_f(input logic d);
        return d && m_addr == ca && m_line >= cs && m_line <= ce
            && !(bl && (sl ? m_f[4] : m_f[3]));
    endfunction

    // Each check sees the effect of the inputs driven one step earlier.
    task step(input logic f, input logic l, input logic d);
        @(posedge clk_i);
        fs <= f;
        le <= l;
        de <= d;
        @(negedge clk_i);
        chk_out({ra, rw, cur}, {m_addr, m_line, m_cur});
        m_cur = cur_f(d & ~f & ~l);
        if (f) begin
            m_addr = sa;
            m_rs = sa;
            m_line = 5'h00;
            m_f++;
        end else if (l) begin
            if (m_line == ms) begin
                m_line = 5'h00;
                m_rs = m_addr;
            end else begin
                m_line++;
                m_addr = m_rs;
            end
        end else if (d) begin
            m_addr++;
        end
    endtask

    task frame;
        step(1'b1, 1'b0, 1'b0);
        for (int r = 0; r < 2; r++) begin
            for (int l = 0; l <= ms; l++) begin
                repeat (6) step(1'b0, 1'b0, 1'b1);
                step(1'b0, 1'b1, 1'b0);
            end
        end
        // Park the raster inputs low, or a held line end pulse would keep
        // stepping the scan counter through the bus traffic that follows.
        step(1'b0, 1'b0, 1'b0);
    endtask

    initial begin
        seed = 98925;
        err_count = 0;
        samples_checked = 0;
        {rst_i, fs, le, de, lp, m_cur, bl, sl} = 8'h80;
        {m_addr, m_rs, sa, ca, m_f} = 61'h0;
        {m_line, ms, cs, ce} = 20'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        host_u.init();
        rdc(6'h12, 32'h0);
        for (int k = 0; k < 5; k++) begin
            v = 8'($random(seed));
            wr(ix[k], v);
            rdc(ix[k], {24'h0, v & mk[k]});
        end
        wr(6'h0c, 8'h3f);
        rdc(6'h0c, 32'h0);
        wr(6'h0d, 8'hff);
        rdc(6'h0d, 32'h0);
        rdc(6'h14, 32'h0);
        for (int k = 0; k < 6; k++) begin
            ms = 5'($random(seed) & 3);
            cs = 5'($random(seed) & 3);
            ce = (k == 0) ? cs : cs + 5'($random(seed) & 1);
            ca = sa + 14'($random(seed) & 7);
            bl = k > 2;
            sl = k[0];
            wr(6'h09, {3'h0, ms});
            wr(6'h0a, {1'b0, bl, sl, cs});
            wr(6'h0b, {3'h0, ce});
            if (k == 2) begin
                host_u.scroll(14'h0006);
                sa = sa + 14'h0006;
            end else begin
                sa = 14'($random(seed));
                host_u.set_start(sa);
            end
            ca = sa + 14'($random(seed) & 7);
            wr(6'h0e, {2'h0, ca[13:8]});
            wr(6'h0f, ca[7:0]);
            for (int n = 0; n < (bl ? 34 : 1); n++) frame();
        end
        step(1'b0, 1'b0, 1'b0);
        @(posedge clk_i);
        lp <= 1'b1;
        repeat (6) @(posedge clk_i);
        lp <= 1'b0;
        repeat (4) @(posedge clk_i);
        rdc(6'h10, {26'h0, m_addr[13:8]});
        rdc(6'h11, {24'h0, m_addr[7:0]});
        rdc(6'h12, 32'h1);
        wr(6'h11, 8'h5a);
        wr(6'h12, 8'h01);
        rdc(6'h11, {24'h0, m_addr[7:0]});
        rdc(6'h12, 32'h0);
        finish_test();
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        err_count++;
        finish_test();
    end
endmodule
